// >>> bench/spcc_remote_uart.sv
// far-side serial sender: 8-bit frames onto the block's receive pin
// assumes a pull-up on the line, so it idles high between frames
`timescale 1ns/1ns
module spcc_remote_uart #(
    parameter int BIT_CYC = 16
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // bench request; holdLow pulls the line low at length
    input  wire logic       send,
    input  wire logic       holdLow,
    input  wire logic [7:0] data,
    // line
    output logic            txd
);
    logic [9:0] frame_reg;
    logic [3:0] bitCnt_reg;
    int         cyc_reg;
    // one start, eight data lsb first, one stop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_reg  <= 10'h3ff;
            bitCnt_reg <= 4'h0;
            cyc_reg    <= 0;
        end else if (bitCnt_reg == 4'h0) begin
            if (send) begin
                frame_reg  <= {1'b1, data, 1'b0};
                bitCnt_reg <= 4'ha;
                cyc_reg    <= BIT_CYC;
            end
        end else if (cyc_reg == 1) begin
            frame_reg  <= {1'b1, frame_reg[9:1]};
            bitCnt_reg <= bitCnt_reg - 4'h1;
            cyc_reg    <= BIT_CYC;
        end else begin
            cyc_reg <= cyc_reg - 1;
        end
    end
    // between frames the pull-up sets the level, not the last bit
    assign txd = holdLow ? 1'b0 : (bitCnt_reg == 4'h0 ? 1'b1 : frame_reg[0]);
endmodule

// >>> bench/spcc_serial_ctrl_props.sv
// port-level checks of the serial port control block
// assumes a bind from the bench top and one apb word per register
`timescale 1ns/1ns
module spcc_serial_ctrl_props
    import spcc_pkg::*;
#(
    parameter logic [15:0] BAUD_DIVIDE = BAUD_DIV
) (
    // clock, reset and bus
    input wire logic         core_clk,
    input wire logic         rst_n,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    input wire logic         pslverr,
    // engine side, pins and requests
    input wire spcc_fmt_type engFormat,
    input wire logic         engEnable,
    input wire logic         engRxEnable,
    input wire logic         serialOutPinOe,
    input wire logic         serialInPinOe,
    input wire logic         baudTick,
    input wire logic         txIrq,
    input wire logic         rxIrq
);
    logic [7:0] one_reg;
    logic [7:0] two_reg;
    logic [1:0] quiet_reg;
    logic       wr;
    logic       quiet;
    // ---------------------------------------------------------------
    // shadow registers
    // ---------------------------------------------------------------
    assign wr    = psel && penable && pwrite;
    assign quiet = quiet_reg == 2'h3;
    // shadow of both control words; enables refused while the module is off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            one_reg <= 8'h00;
            two_reg <= 8'h00;
        end else if (wr && paddr == CTRL_ONE_OFS) begin
            one_reg <= pwdata[7:0];
        end else if (wr && paddr == CTRL_TWO_OFS) begin
            two_reg <= {pwdata[7:4], one_reg[ENA_BIT] ? pwdata[3:2] : two_reg[3:2], 2'b00};
        end
    end
    // settle time after a write, registered copies may lag by one edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) quiet_reg <= 2'h0;
        else if (wr) quiet_reg <= 2'h0;
        else if (!quiet) quiet_reg <= quiet_reg + 2'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_unmapped_err: assert property (psel && penable &&
        (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0) |-> pslverr) else $error("no bus error");
    a_format_copy: assert property (quiet |-> engFormat == {one_reg[LEN_BIT],
        one_reg[PAR_BIT], one_reg[ODD_BIT], one_reg[WAKE_BIT], one_reg[IDLEO_BIT]}) else $error("format");
    a_enable_copy: assert property (quiet |-> engEnable == one_reg[ENA_BIT])
        else $error("module enable");
    a_out_pin_own: assert property (engEnable [*4] |-> serialOutPinOe)
        else $error("out pin not driven");
    a_in_pin_own: assert property (engEnable [*4] |-> !serialInPinOe)
        else $error("in pin driven");
    a_baud_gated: assert property (quiet && !one_reg[ENA_BIT] |-> !baudTick)
        else $error("baud while off");
    a_baud_pulse: assert property (baudTick && BAUD_DIVIDE > 16'h0001 |=> !baudTick)
        else $error("baud tick too long");
    a_tx_irq_mask: assert property (quiet && !(one_reg[ENA_BIT] &&
        (two_reg[TXEIE_BIT] || two_reg[TXDIE_BIT])) |-> !txIrq) else $error("tx request");
    a_rx_irq_mask: assert property (quiet && !two_reg[RXFIE_BIT] &&
        !two_reg[IDLIE_BIT] |-> !rxIrq) else $error("rx request");
    a_rx_en_copy: assert property (quiet |->
        engRxEnable == (two_reg[RXEN_BIT] && one_reg[ENA_BIT])) else $error("rx enable");
    c_tx_irq: cover property ($rose(txIrq));
    c_rx_irq: cover property ($rose(rxIrq));
    c_parity: cover property (engEnable && engFormat.parityOn);
endmodule

// >>> bench/tb_spcc_serial_ctrl.sv
// self-checking bench for the serial port control block
// assumes the checker and the remote sender are compiled ahead of it
`timescale 1ns/1ns
module tb_spcc_serial_ctrl
    import spcc_pkg::*;
;
    logic         core_clk, rst_n, psel, penable, pwrite, pready, pslverr, send, holdLow;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         debugBreak, breakClearFlagEnable, outPinDirectionBit, inPinDirectionBit;
    logic         portOutData, serialInPin, serialOutPin, serialOutPinOe, serialInPinOe;
    logic         engTxBit, engTxBusy, engTxLoad, engRxFull, engRxIdle, engEnable;
    logic         engRxEnable, engRxBit, baudTick, txIrq, rxIrq;
    logic [7:0]   pdat, cfg;
    spcc_fmt_type engFormat;
    int           num_errors = 0, n_tests = 0, cyc = 0;
    // short baud divide keeps the run brief
    spcc_serial_ctrl #(.BAUD_DIVIDE(16'h0004)) u_spcc_serial_ctrl (.core_clk, .rst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .debugBreak,
        .breakClearFlagEnable, .outPinDirectionBit, .inPinDirectionBit, .portOutData,
        .serialInPin, .serialOutPin, .serialOutPinOe, .serialInPinOe, .engTxBit, .engTxBusy,
        .engTxLoad, .engRxFull, .engRxIdle, .engFormat, .engEnable, .engRxEnable, .engRxBit,
        .baudTick, .txIrq, .rxIrq);
    spcc_remote_uart #(.BIT_CYC(16)) u_spcc_remote_uart (.core_clk, .rst_n, .send, .holdLow,
        .data(pdat), .txd(serialInPin));
    // clock and hang guard
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            num_errors = num_errors + 1;
            test_done();
        end
    end
    // ---------------------------------------------------------------
    // bench tasks and expectations
    // ---------------------------------------------------------------
    task automatic test_done();
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        tick(1);
        penable <= 1'b1;
        do tick(1); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    task automatic flag(input int b, input logic v);
        apb(1'b0, STATUS_OFS, 8'h00);
        chk(32'(rd[b]), 32'(v));
    endtask
    task automatic rxev(input logic idle);
        engRxFull <= !idle;
        engRxIdle <= idle;
        tick(1);
        engRxFull <= 1'b0;
        engRxIdle <= 1'b0;
        tick(3);
    endtask
    function automatic spcc_fmt_type fmt_exp(input logic [7:0] c);
        return '{c[LEN_BIT], c[PAR_BIT], c[ODD_BIT], c[WAKE_BIT], c[IDLEO_BIT]};
    endfunction
    function automatic logic frame_bit(input logic [7:0] d, input int i);
        return (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
    endfunction
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, debugBreak, breakClearFlagEnable} = '0;
        {outPinDirectionBit, inPinDirectionBit, portOutData, engTxBit, engTxBusy} = '0;
        {engTxLoad, engRxFull, engRxIdle, send, holdLow, pdat} = '0;
        void'($urandom(32'hcf05));
        tick(16);
        rst_n <= 1'b1;
        tick(1);
        rdchk(CTRL_ONE_OFS, 32'h0);
        rdchk(CTRL_TWO_OFS, 32'h0);
        rdchk(STATUS_OFS, 32'(FLAG_RST));
        rdchk(12'h010, 32'h0);
        apb(1'b1, CTRL_TWO_OFS, 8'h0c);
        rdchk(CTRL_TWO_OFS, 32'h0);
        // random formats, enables and pin directions, module on, loop and transmit enable off
        repeat (12) begin
            cfg = (8'($urandom) & 8'h7f) | 8'h40;
            pdat = 8'($urandom) & 8'hf7;
            outPinDirectionBit <= 1'($urandom);
            inPinDirectionBit <= 1'($urandom);
            portOutData <= 1'($urandom);
            engTxBit <= 1'($urandom);
            apb(1'b1, CTRL_ONE_OFS, cfg);
            apb(1'b1, CTRL_TWO_OFS, pdat);
            rdchk(CTRL_ONE_OFS, 32'(cfg));
            rdchk(CTRL_TWO_OFS, 32'(pdat & 8'hf4));
            chk(32'(engFormat), 32'(fmt_exp(cfg)));
            chk(32'(serialOutPin), 32'(!cfg[INV_BIT]));
            chk(32'({serialOutPinOe, serialInPinOe}), 32'h2);
            chk(32'(txIrq), 32'(pdat[TXEIE_BIT] | pdat[TXDIE_BIT]));
        end
        // loopback ignores a low pin; normal mode follows a real frame
        apb(1'b1, CTRL_ONE_OFS, 8'he0);
        apb(1'b1, CTRL_TWO_OFS, 8'h0c);
        holdLow <= 1'b1;
        tick(8);
        chk(32'(engRxBit), 32'h1);
        chk(32'(serialOutPin), 32'h0);
        apb(1'b1, CTRL_ONE_OFS, 8'h40);
        tick(8);
        chk(32'(engRxBit), 32'h0);
        holdLow <= 1'b0;
        pdat = 8'($urandom);
        tick(4);
        send <= 1'b1;
        tick(1);
        send <= 1'b0;
        tick(10);
        for (int i = 0; i < 10; i++) begin
            chk(32'(engRxBit), 32'(frame_bit(pdat, i)));
            tick(16);
        end
        // receive flags, requests and break protection
        apb(1'b1, CTRL_TWO_OFS, 8'h24);
        rxev(1'b0);
        chk(32'(rxIrq), 32'h1);
        apb(1'b1, CTRL_TWO_OFS, 8'h20);
        flag(RXF_FLAG, 1'b1);
        debugBreak <= 1'b1;
        apb(1'b1, CLR_OFS, 8'h04);
        flag(RXF_FLAG, 1'b1);
        debugBreak <= 1'b0;
        apb(1'b1, CLR_OFS, 8'h04);
        flag(RXF_FLAG, 1'b0);
        chk(32'(rxIrq), 32'h0);
        rxev(1'b0);
        flag(RXF_FLAG, 1'b1);
        debugBreak <= 1'b1;
        breakClearFlagEnable <= 1'b1;
        apb(1'b1, CLR_OFS, 8'h04);
        debugBreak <= 1'b0;
        flag(RXF_FLAG, 1'b0);
        apb(1'b1, CTRL_TWO_OFS, 8'h10);
        rxev(1'b1);
        chk(32'(rxIrq), 32'h1);
        flag(IDL_FLAG, 1'b1);
        // engine bits reach the pin; a re-enable mid frame queues an idle character
        engTxBit <= 1'b0;
        engTxBusy <= 1'b1;
        tick(4);
        chk(32'(serialOutPin), 32'h0);
        flag(TXD_FLAG, 1'b1);
        apb(1'b1, CLR_OFS, 8'h02);
        apb(1'b1, CTRL_TWO_OFS, 8'h18);
        engTxBusy <= 1'b0;
        tick(8);
        flag(TXD_FLAG, 1'b0);
        tick(40);
        flag(TXD_FLAG, 1'b1);
        // module off sets both tx flags even after a clear and masks tx requests
        apb(1'b1, CTRL_TWO_OFS, 8'hc0);
        apb(1'b1, CLR_OFS, 8'h03);
        apb(1'b1, CTRL_ONE_OFS, 8'h00);
        flag(TXE_FLAG, 1'b1);
        flag(TXD_FLAG, 1'b1);
        chk(32'(txIrq), 32'h0);
        test_done();
    end
endmodule
bind spcc_serial_ctrl spcc_serial_ctrl_props #(.BAUD_DIVIDE(BAUD_DIVIDE)) u_spcc_serial_ctrl_props (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .engFormat,
    .engEnable, .engRxEnable, .serialOutPinOe, .serialInPinOe, .baudTick, .txIrq, .rxIrq);

// >>> rtl/spcc_pkg.sv
// constants, field layouts and carrier types for the serial port control block
// assumes an apb slave wrapper in the same module and a neighbouring bit engine
package spcc_pkg;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [11:0] CTRL_ONE_OFS  = 12'h000;
    localparam logic [11:0] CTRL_TWO_OFS  = 12'h004;
    localparam logic [11:0] STATUS_OFS    = 12'h008;
    localparam logic [11:0] CLR_OFS       = 12'h00c;
    // ---------------------------------------------------------------
    // control one fields
    // ---------------------------------------------------------------
    localparam int LOOP_BIT   = 7;
    localparam int ENA_BIT    = 6;
    localparam int INV_BIT    = 5;
    localparam int LEN_BIT    = 4;
    localparam int WAKE_BIT   = 3;
    localparam int IDLEO_BIT  = 2;
    localparam int PAR_BIT    = 1;
    localparam int ODD_BIT    = 0;
    // control two fields
    localparam int TXEIE_BIT  = 7;
    localparam int TXDIE_BIT  = 6;
    localparam int RXFIE_BIT  = 5;
    localparam int IDLIE_BIT  = 4;
    localparam int TXEN_BIT   = 3;
    localparam int RXEN_BIT   = 2;
    // status / clear fields
    localparam int TXE_FLAG   = 0;
    localparam int TXD_FLAG   = 1;
    localparam int RXF_FLAG   = 2;
    localparam int IDL_FLAG   = 3;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [3:0] FLAG_RST   = 4'h3;
    localparam logic [3:0] SHORT_LEN  = 4'ha;
    localparam logic [3:0] LONG_LEN   = 4'hb;
    localparam logic [15:0] BAUD_DIV  = 16'h0044;

    // decoded format handed to the bit engine
    typedef struct packed {
        logic nineBit;
        logic parityOn;
        logic parityOdd;
        logic wakeAddr;
        logic idleAfterStop;
    } spcc_fmt_type;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_PRE   = 4'b0010,
        TX_FRAME = 4'b0100,
        TX_IDLCH = 4'b1000
    } spcc_tx_state_type;
endpackage

// >>> rtl/spcc_serial_ctrl.sv
// serial port control: apb registers, pin ownership, preamble/idle framing,
// flag protection under debug break and interrupt request gating
// assumes the bit engine supplies frame events and serial data bits
`timescale 1ns/1ns
module spcc_serial_ctrl
    import spcc_pkg::*;
#(
    parameter logic [15:0] BAUD_DIVIDE = BAUD_DIV
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic               pslverr,
    output logic [31:0]        prdata,
    // system break state
    input  wire logic          debugBreak,
    input  wire logic          breakClearFlagEnable,
    // port direction bits from the pin port
    input  wire logic          outPinDirectionBit,
    input  wire logic          inPinDirectionBit,
    input  wire logic          portOutData,
    // pins
    input  wire logic          serialInPin,
    output logic               serialOutPin,
    output logic               serialOutPinOe,
    output logic               serialInPinOe,
    // bit engine side
    input  wire logic          engTxBit,
    input  wire logic          engTxBusy,
    input  wire logic          engTxLoad,
    input  wire logic          engRxFull,
    input  wire logic          engRxIdle,
    output spcc_fmt_type       engFormat,
    output logic               engEnable,
    output logic               engRxEnable,
    output logic               engRxBit,
    output logic               baudTick,
    // interrupt requests
    output logic               txIrq,
    output logic               rxIrq
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0]        ctrlOne_reg;
    logic [7:0]        ctrlTwo_reg;
    logic [3:0]        flags_reg;
    logic [3:0]        armed_reg;
    logic [15:0]       baudCnt_reg;
    logic [2:0]        rxSync_reg;
    logic              rxIn_reg;
    logic              txOut_reg;
    logic [3:0]        bitCnt_reg;
    logic              idleQueued_reg;
    logic              txEnPrev_reg;
    spcc_tx_state_type txState_reg;

    // bus decode and decoded control bits
    logic       wrTake;
    logic       rdTake;
    logic       modEn;
    logic       txEn;
    logic [3:0] clearReq;
    logic [3:0] setReq;
    logic [3:0] frameLen;
    logic       txLine;

    // zero wait states: every access completes in its first access cycle
    assign wrTake  = psel && penable && pwrite;
    assign rdTake  = psel && penable && !pwrite;
    assign modEn   = ctrlOne_reg[ENA_BIT];
    assign txEn    = ctrlTwo_reg[TXEN_BIT];
    assign pready  = 1'b1;
    // unmapped addresses answer with an error
    assign pslverr = psel && penable && !(paddr == CTRL_ONE_OFS || paddr == CTRL_TWO_OFS
                     || paddr == STATUS_OFS || paddr == CLR_OFS);
    assign frameLen = ctrlOne_reg[LEN_BIT] ? LONG_LEN : SHORT_LEN;

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    // writes land on the edge that completes the access
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlOne_reg <= CTRL_RST;
        end else if (wrTake && paddr == CTRL_ONE_OFS) begin
            ctrlOne_reg <= pwdata[7:0];
        end
    end

    // enables only stick while the module is on; low bits reserved
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlTwo_reg <= CTRL_RST;
        end else if (wrTake && paddr == CTRL_TWO_OFS) begin
            ctrlTwo_reg[7:4] <= pwdata[7:4];
            if (modEn) begin
                ctrlTwo_reg[TXEN_BIT] <= pwdata[TXEN_BIT];
                ctrlTwo_reg[RXEN_BIT] <= pwdata[RXEN_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    // loaded in the setup cycle so it already stands during the access phase
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                CTRL_ONE_OFS: prdata <= {24'h00_0000, ctrlOne_reg};
                CTRL_TWO_OFS: prdata <= {24'h00_0000, ctrlTwo_reg};
                STATUS_OFS:   prdata <= {24'h00_0000, armed_reg, flags_reg};
                default:      prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // status flags with two-step clear
    // ---------------------------------------------------------------
    // status read arms, write-one to clear register completes the clear
    always_comb begin
        setReq             = 4'h0;
        setReq[TXE_FLAG]   = engTxLoad || !modEn;
        setReq[TXD_FLAG]   = (flags_reg[TXE_FLAG] && !engTxBusy && txState_reg == TX_IDLE)
                             || !modEn;
        setReq[RXF_FLAG]   = engRxFull;
        setReq[IDL_FLAG]   = engRxIdle;
        clearReq           = 4'h0;
        if (wrTake && paddr == CLR_OFS) begin
            clearReq = pwdata[3:0] & armed_reg;
        end
        // protected break: no access moves a flag
        if (debugBreak && !breakClearFlagEnable) begin
            clearReq = 4'h0;
        end
    end

    // set beats clear in the same cycle; break-time clears persist
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= FLAG_RST;
        end else begin
            flags_reg <= (flags_reg & ~clearReq) | setReq;
        end
    end

    // arming survives a protected break so the second step works after it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 4'h0;
        end else if (debugBreak && !breakClearFlagEnable) begin
            armed_reg <= armed_reg;
        end else if (rdTake && paddr == STATUS_OFS) begin
            armed_reg <= flags_reg;
        end else begin
            armed_reg <= armed_reg & ~clearReq;
        end
    end

    // ---------------------------------------------------------------
    // baud divider
    // ---------------------------------------------------------------
    // stops when the module is off to save power
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            baudCnt_reg <= 16'h0000;
        end else if (!modEn || baudCnt_reg == BAUD_DIVIDE - 16'h0001) begin
            baudCnt_reg <= 16'h0000;
        end else begin
            baudCnt_reg <= baudCnt_reg + 16'h0001;
        end
    end
    // combinational so framing sees the tick in the cycle it occurs
    assign baudTick = modEn && baudCnt_reg == BAUD_DIVIDE - 16'h0001;

    // ---------------------------------------------------------------
    // transmit framing: preamble, queued idle, hand-off to engine bits
    // ---------------------------------------------------------------
    // last transmitter enable, for the rising-edge detect
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txEnPrev_reg <= 1'b0;
        end else begin
            txEnPrev_reg <= txEn;
        end
    end

    // a re-enable while busy means idle follows the current frame
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idleQueued_reg <= 1'b0;
        end else if (txEn && !txEnPrev_reg && engTxBusy) begin
            idleQueued_reg <= 1'b1;
        end else if (txState_reg == TX_IDLCH) begin
            idleQueued_reg <= 1'b0;
        end
    end

    // state and bit count move together; module off drops any framing in flight
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txState_reg <= TX_IDLE;
            bitCnt_reg  <= 4'h0;
        end else if (!modEn) begin
            txState_reg <= TX_IDLE;
            bitCnt_reg  <= 4'h0;
        end else begin
            unique case (txState_reg)
                TX_IDLE: begin
                    if (txEn && !txEnPrev_reg && !engTxBusy) begin
                        txState_reg <= TX_PRE;
                        bitCnt_reg  <= frameLen;
                    end else if (engTxBusy) begin
                        txState_reg <= TX_FRAME;
                    end
                end
                TX_PRE, TX_IDLCH: begin
                    if (baudTick) begin
                        bitCnt_reg <= bitCnt_reg - 4'h1;
                        if (bitCnt_reg == 4'h1) begin
                            txState_reg <= TX_IDLE;
                        end
                    end
                end
                TX_FRAME: begin
                    // current character finishes even with tx off; module off drops it
                    if (!engTxBusy) begin
                        txState_reg <= idleQueued_reg ? TX_IDLCH : TX_IDLE;
                        bitCnt_reg  <= frameLen;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // pins
    // ---------------------------------------------------------------
    // preamble and queued idle send ones; only frames pass engine bits
    assign txLine = (txState_reg == TX_FRAME) ? engTxBit : 1'b1;

    // registered so the pin never glitches on state decode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txOut_reg <= 1'b1;
        end else begin
            txOut_reg <= txLine ^ ctrlOne_reg[INV_BIT];
        end
    end

    // out pin data: transmitter while enabled, the port latch otherwise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serialOutPin <= 1'b0;
        end else begin
            serialOutPin <= modEn ? txOut_reg : portOutData;
        end
    end

    // module owns the pins while enabled; port logic otherwise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serialOutPinOe <= 1'b0;
            serialInPinOe  <= 1'b0;
        end else begin
            serialOutPinOe <= modEn || outPinDirectionBit;
            serialInPinOe  <= !modEn && inPinDirectionBit;
        end
    end

    // three-stage pin sampler, change taken when stages two and three agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxSync_reg <= 3'b111;
            rxIn_reg   <= 1'b1;
        end else begin
            rxSync_reg <= {rxSync_reg[1:0], serialInPin};
            if (rxSync_reg[1] == rxSync_reg[2]) begin
                rxIn_reg <= rxSync_reg[2];
            end
        end
    end

    // loopback taps the uninverted transmitter, not the pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            engRxBit <= 1'b1;
        end else begin
            engRxBit <= ctrlOne_reg[LOOP_BIT] ? txLine : rxIn_reg;
        end
    end

    // ---------------------------------------------------------------
    // engine controls and requests
    // ---------------------------------------------------------------
    // format copy trails control one by one edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            engFormat <= '0;
        end else begin
            engFormat.nineBit       <= ctrlOne_reg[LEN_BIT];
            engFormat.parityOn      <= ctrlOne_reg[PAR_BIT];
            engFormat.parityOdd     <= ctrlOne_reg[ODD_BIT];
            engFormat.wakeAddr      <= ctrlOne_reg[WAKE_BIT];
            engFormat.idleAfterStop <= ctrlOne_reg[IDLEO_BIT];
        end
    end

    // engine enables; the receiver also needs the module on
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            engEnable   <= 1'b0;
            engRxEnable <= 1'b0;
        end else begin
            engEnable   <= modEn;
            engRxEnable <= modEn && ctrlTwo_reg[RXEN_BIT];
        end
    end

    // requests are levels; tx side masked while the module is off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txIrq <= 1'b0;
            rxIrq <= 1'b0;
        end else begin
            txIrq <= modEn && ((ctrlTwo_reg[TXEIE_BIT] && flags_reg[TXE_FLAG])
                     || (ctrlTwo_reg[TXDIE_BIT] && flags_reg[TXD_FLAG]));
            rxIrq <= (ctrlTwo_reg[RXFIE_BIT] && flags_reg[RXF_FLAG])
                     || (ctrlTwo_reg[IDLIE_BIT] && flags_reg[IDL_FLAG]);
        end
    end
endmodule
